// ==== verilog/move_exec.sv ====
// Execute slice for the data-move and idle instructions of the 14-bit core.
//
// Operation
// RL1 - PC change or true test takes two cycles.
// RL2 - Stretched second cycle behaves as idle instruction.
// RL3 - Copy with d clear loads accumulator from register.
// RL4 - Copy with d set rewrites register with itself.
// RL5 - Copy updates zero flag only from moved value.
// RL6 - Store writes accumulator to register, no flags.
// RL7 - Load immediate puts literal in accumulator, no flags.
// RL8 - Fetch side fills load immediate don't-cares with zero.
// RL9 - Copy decoded from 00 1000 dfff ffff.
// RL10 - Idle decoded from 00 0000 0xx0 0000, no state.
// RL11 - These four instructions are one word, one cycle.
`timescale 1ns/1ps

module move_exec
	import move_exec_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire fetch_s fetch,
	output logic ready,
	output file_wr_s file_wr,
	output logic [DATA_W-1:0] acc,
	output logic zero,
	output logic zero_we,
	output logic pc_adv
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	exec_s s_q;
	exec_s s_d;
	logic take;
	logic is_copy;
	logic is_store;
	logic is_load;
	logic is_idle;
	logic dest_self;
	logic [ADDR_W-1:0] f_addr;
	logic [DATA_W-1:0] literal;

	// An instruction is accepted only in a run cycle with ready shown.
	assign take = fetch.valid && s_q.ready && (s_q.phase == PH_RUN);

	assign is_copy = (fetch.word & COPY_MASK) == COPY_MATCH; // [RL9]
	assign is_store = (fetch.word & STORE_MASK) == STORE_MATCH;
	// The literal don't-care bits are masked, so a stray one there is harmless. [RL8]
	assign is_load = (fetch.word & LOAD_MASK) == LOAD_MATCH;
	assign is_idle = (fetch.word & IDLE_MASK) == IDLE_MATCH; // [RL10]

	assign dest_self = fetch.word[DEST_BIT]; // [RL9]
	assign f_addr = fetch.word[ADDR_LSB +: ADDR_W];
	assign literal = fetch.word[LIT_LSB +: DATA_W];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.file_wr.we = 1'b0;
		s_d.zero_we = 1'b0;
		s_d.pc_adv = 1'b0;
		case (s_q.phase)
			PH_RUN: begin
				s_d.ready = 1'b1;
				if (take) begin
					// Each of these completes in the cycle it is taken. [RL11]
					s_d.pc_adv = 1'b1;
					if (is_copy) begin
						s_d.zero = (fetch.rdata == '0); // [RL5]
						s_d.zero_we = 1'b1; // [RL5]
						if (dest_self) begin
							s_d.file_wr.we = 1'b1; // [RL4]
							s_d.file_wr.addr = f_addr; // [RL4]
							s_d.file_wr.data = fetch.rdata; // [RL4]
						end else begin
							s_d.acc = fetch.rdata; // [RL3]
						end
					end else if (is_store) begin
						s_d.file_wr.we = 1'b1; // [RL6]
						s_d.file_wr.addr = f_addr; // [RL6]
						s_d.file_wr.data = s_q.acc; // [RL6]
					end else if (is_load) begin
						s_d.acc = literal; // [RL7]
					end
					// Idle and foreign instructions touch nothing here. [RL10]
					if (fetch.stretch) begin
						// The extra cycle is held back from fetch. [RL1]
						s_d.phase = PH_FILL;
						s_d.ready = 1'b0;
					end
				end
			end
			PH_FILL: begin
				// Nothing is written and the program counter holds. [RL2]
				s_d.phase = PH_RUN;
				s_d.ready = 1'b1;
			end
			default: begin
				s_d.phase = PH_RUN;
				s_d.ready = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q.phase <= PH_RUN;
			s_q.ready <= 1'b0;
			s_q.acc <= ACC_RESET;
			s_q.zero <= ZERO_RESET;
			s_q.zero_we <= 1'b0;
			s_q.pc_adv <= 1'b0;
			s_q.file_wr <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ready = s_q.ready;
	assign file_wr = s_q.file_wr;
	assign acc = s_q.acc;
	assign zero = s_q.zero;
	assign zero_we = s_q.zero_we;
	assign pc_adv = s_q.pc_adv;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_stretch_two_cycles: assert property ( // [RL1]
		@(posedge clk) disable iff (reset)
		(take && fetch.stretch) |=> !ready ##1 ready
	) else $error("stretched instruction did not hold ready low for one cycle");

	a_fill_is_idle: assert property ( // [RL2]
		@(posedge clk) disable iff (reset)
		(take && fetch.stretch) |=> ##1 (!file_wr.we && !zero_we && !pc_adv && $stable(acc))
	) else $error("second cycle of a stretched instruction changed state");

	a_copy_to_acc: assert property ( // [RL3]
		@(posedge clk) disable iff (reset)
		(take && is_copy && !dest_self) |=> (acc == $past(fetch.rdata)) && !file_wr.we
	) else $error("copy to accumulator moved the wrong value");

	a_copy_to_self: assert property ( // [RL4]
		@(posedge clk) disable iff (reset)
		(take && is_copy && dest_self) |=> file_wr.we && (file_wr.addr == $past(f_addr))
			&& (file_wr.data == $past(fetch.rdata)) && $stable(acc)
	) else $error("copy to self did not rewrite the register");

	a_copy_zero_flag: assert property ( // [RL5]
		@(posedge clk) disable iff (reset)
		(take && is_copy) |=> zero_we && (zero == ($past(fetch.rdata) == 8'h00))
	) else $error("copy did not set the zero flag from the moved value");

	a_store_write: assert property ( // [RL6]
		@(posedge clk) disable iff (reset)
		(take && is_store) |=> file_wr.we && (file_wr.data == $past(acc))
			&& (file_wr.addr == $past(f_addr)) && !zero_we
	) else $error("store did not write the accumulator cleanly");

	a_load_literal: assert property ( // [RL7]
		@(posedge clk) disable iff (reset)
		(take && is_load) |=> (acc == $past(literal)) && !zero_we && !file_wr.we
	) else $error("load immediate did not place the literal");

	a_idle_quiet: assert property ( // [RL10]
		@(posedge clk) disable iff (reset)
		(take && is_idle) |=> pc_adv && !file_wr.we && !zero_we && $stable(acc) && $stable(zero)
	) else $error("idle instruction changed state");

	a_single_cycle: assert property ( // [RL11]
		@(posedge clk) disable iff (reset)
		(take && !fetch.stretch) |=> ready && pc_adv
	) else $error("unstretched instruction did not finish in one cycle");

	a_refuse_when_busy: assert property ( // [RL1]
		@(posedge clk) disable iff (reset)
		(fetch.valid && !ready) |=> !pc_adv && !file_wr.we && !zero_we
	) else $error("word accepted while ready was low");

	a_fill_keeps_flags: assert property ( // [RL2]
		@(posedge clk) disable iff (reset)
		(s_q.phase == PH_FILL) |=> $stable(acc) && $stable(zero)
	) else $error("stretch cycle changed the accumulator or the zero flag");

	// Every strobe must trace back to a word taken one edge earlier.
	a_pc_needs_take: assert property ( // [RL11]
		@(posedge clk) disable iff (reset)
		pc_adv |-> $past(take)
	) else $error("program counter advanced without a taken word");

	a_zero_only_copy: assert property ( // [RL5]
		@(posedge clk) disable iff (reset)
		zero_we |-> $past(take) && $past(is_copy)
	) else $error("zero flag strobed by an instruction other than copy");

	a_write_source: assert property ( // [RL4] [RL6]
		@(posedge clk) disable iff (reset)
		file_wr.we |-> $past(take) && ($past(is_store) || ($past(is_copy) && $past(dest_self)))
	) else $error("file register written by an instruction that does not write");

	a_store_keeps_flags: assert property ( // [RL6]
		@(posedge clk) disable iff (reset)
		(take && is_store) |=> $stable(acc) && $stable(zero)
	) else $error("store changed the accumulator or the zero flag");

	a_load_keeps_zero: assert property ( // [RL7]
		@(posedge clk) disable iff (reset)
		(take && is_load) |=> $stable(zero)
	) else $error("load immediate changed the zero flag");

	a_quiet_without_take: assert property ( // [RL10]
		@(posedge clk) disable iff (reset)
		!take |=> !pc_adv && !file_wr.we && !zero_we && $stable(acc) && $stable(zero)
	) else $error("state changed in a cycle with no taken word");

endmodule

// ==== verilog/move_exec_pkg.sv ====
// Constants, encodings and carrier types for the data-move execute slice.
package move_exec_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;

	// ----------------------------------------------------------------
	// Field positions inside the instruction word
	// ----------------------------------------------------------------
	localparam int DEST_BIT = 7;
	localparam int ADDR_LSB = 0;
	localparam int LIT_LSB = 0;

	// ----------------------------------------------------------------
	// Opcode patterns: a word matches when (word & mask) == match
	// ----------------------------------------------------------------
	localparam logic [INSTR_W-1:0] COPY_MASK = 14'h3f00;
	localparam logic [INSTR_W-1:0] COPY_MATCH = 14'h0800;
	localparam logic [INSTR_W-1:0] STORE_MASK = 14'h3f80;
	localparam logic [INSTR_W-1:0] STORE_MATCH = 14'h0080;
	localparam logic [INSTR_W-1:0] LOAD_MASK = 14'h3c00;
	localparam logic [INSTR_W-1:0] LOAD_MATCH = 14'h3000;
	localparam logic [INSTR_W-1:0] IDLE_MASK = 14'h3f9f;
	localparam logic [INSTR_W-1:0] IDLE_MATCH = 14'h0000;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic ZERO_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		PH_RUN = 1'b0,
		PH_FILL = 1'b1
	} phase_e;

	typedef struct packed {
		logic valid;
		logic [INSTR_W-1:0] word;
		logic [DATA_W-1:0] rdata;
		logic stretch;
	} fetch_s;

	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} file_wr_s;

	typedef struct packed {
		phase_e phase;
		logic ready;
		logic [DATA_W-1:0] acc;
		logic zero;
		logic zero_we;
		logic pc_adv;
		file_wr_s file_wr;
	} exec_s;

endpackage

// ==== bench/data_move_instruction_exec_tb_top.sv ====
// Self-checking testbench for the data-move execute slice.
`timescale 1ns/1ps

module data_move_instruction_exec_tb_top
	import move_exec_pkg::*;
;
	logic clk;
	logic reset;
	fetch_s fetch;
	logic ready;
	file_wr_s file_wr;
	logic [DATA_W-1:0] acc;
	logic zero;
	logic zero_we;
	logic pc_adv;
	int n_mismatch;
	int cmp_count;
	logic [7:0] m_acc;
	logic m_zero;

	move_exec i_dut (.clk(clk), .reset(reset), .fetch(fetch), .ready(ready),
		.file_wr(file_wr), .acc(acc), .zero(zero), .zero_we(zero_we), .pc_adv(pc_adv));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task finish_test;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Opcode classes straight from the bit patterns: 1 copy, 2 store, 3 load, 0 other.
	function automatic logic [1:0] op_kind(input logic [13:0] w);
		if (w[13:8] == 6'h08) return 2'h1;
		if (w[13:7] == 7'h01) return 2'h2;
		if (w[13:10] == 4'hc) return 2'h3;
		return 2'h0;
	endfunction

	// Expected results are folded into the model accumulator and zero flag.
	task run(input logic [13:0] w, input logic [7:0] rd, input logic st);
		int i;
		logic ew;
		logic ez;
		logic [7:0] ed;
		i = 0;
		while (ready !== 1'b1) begin
			if (i == 20) begin
				n_mismatch++;
				finish_test();
			end
			i++;
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		fetch <= '{1'b1, w, rd, st};
		@(posedge clk);
		fetch.valid <= 1'b0;
		#1;
		ew = 1'b0;
		ez = 1'b0;
		ed = m_acc;
		if (op_kind(w) == 2'h1) begin
			ez = 1'b1;
			m_zero = (rd == 8'h00);
			if (w[DEST_BIT]) begin
				ew = 1'b1;
				ed = rd;
			end else
				m_acc = rd;
		end else if (op_kind(w) == 2'h2)
			ew = 1'b1;
		else if (op_kind(w) == 2'h3)
			m_acc = w[7:0];
		chk("acc", m_acc, acc);
		chk("zero_we", {7'h00, ez}, {7'h00, zero_we});
		chk("zero", {7'h00, m_zero}, {7'h00, zero});
		chk("we", {7'h00, ew}, {7'h00, file_wr.we});
		if (ew) chk("addr", {1'b0, w[6:0]}, {1'b0, file_wr.addr});
		if (ew) chk("data", ed, file_wr.data);
		chk("pc_adv", 8'h01, {7'h00, pc_adv});
		chk("ready", {7'h00, !st}, {7'h00, ready});
		if (st) begin
			@(posedge clk);
			#1;
			chk("ready2", 8'h01, {7'h00, ready});
			chk("pc_adv2", 8'h00, {7'h00, pc_adv});
			chk("we2", 8'h00, {7'h00, file_wr.we | zero_we});
			chk("acc2", m_acc, acc);
		end
	endtask

	initial begin
		logic [13:0] w;
		logic [7:0] rd;
		int k;
		reset = 1'b1;
		fetch = '0;
		n_mismatch = 0;
		cmp_count = 0;
		m_acc = ACC_RESET;
		m_zero = ZERO_RESET;
		void'($urandom(32'heee3));
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		// Literal with zeroed don't-care bits.
		run(14'h30ff, 8'h00, 1'b0);
		run(14'h087f, 8'h00, 1'b0);
		run(14'h08ff, 8'h5a, 1'b0);
		run(14'h00ff, 8'h00, 1'b1);
		run(14'h0060, 8'h33, 1'b0);
		run(14'h0700, 8'h11, 1'b1);
		// A word offered in the stretch cycle is refused and stays pending.
		@(posedge clk);
		fetch <= '{1'b1, 14'h30a5, 8'h00, 1'b1};
		@(posedge clk);
		fetch <= '{1'b1, 14'h0081, 8'h3c, 1'b0};
		@(posedge clk);
		#1;
		chk("busy_acc", 8'ha5, acc);
		chk("busy_pc", 8'h00, {6'h00, pc_adv, file_wr.we});
		@(posedge clk);
		fetch.valid <= 1'b0;
		#1;
		chk("late_we", 8'h01, {7'h00, file_wr.we});
		chk("late_data", 8'ha5, file_wr.data);
		chk("late_addr", 8'h01, {1'b0, file_wr.addr});
		m_acc = 8'ha5;
		for (int n = 0; n < 300; n++) begin
			k = $urandom % 5;
			rd = 8'($urandom);
			w = 14'($urandom);
			case (k)
				0: w = COPY_MATCH | (w & 14'h00ff);
				1: w = STORE_MATCH | (w & 14'h007f);
				2: w = LOAD_MATCH | (w & 14'h00ff);
				3: w = IDLE_MATCH | (w & 14'h0060);
				default: w = 14'h0700 | (w & 14'h00ff);
			endcase
			if ($urandom % 4 == 0) rd = 8'h00;
			run(w, rd, ($urandom % 4) == 0);
		end
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("acc_rst", ACC_RESET, acc);
		chk("ready_rst", 8'h00, {7'h00, ready});
		chk("strobe_rst", 8'h00, {4'h0, zero, file_wr.we, zero_we, pc_adv});
		m_acc = ACC_RESET;
		m_zero = ZERO_RESET;
		@(posedge clk);
		reset <= 1'b0;
		run(14'h0880, 8'h00, 1'b0);
		run(14'h0085, 8'h00, 1'b0);
		finish_test();
	end
endmodule
